// ===== empsh_bclk.sv
// Burst clock divider for synchronous memories.
// Assumes DIV is even and at least two; the clock idles low outside burst mode.
`timescale 1ns/1ps
module empsh_bclk #(
	parameter int DIV = empsh_pkg::BCLK_DIV
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run,
	output logic bclk,
	output logic rise
);
	logic [7:0] cnt;
	logic [7:0] next_cnt;
	logic next_bclk;
	logic next_rise;
	always_comb begin
		next_cnt = 8'h00;
		next_bclk = 1'h0;
		next_rise = 1'h0;
		if (run) begin
			if (cnt == 8'(DIV / 2 - 1)) begin
				next_bclk = ~bclk;
				next_rise = ~bclk;
			end else begin
				next_cnt = cnt + 8'h01;
				next_bclk = bclk;
			end
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 8'h00;
			bclk <= 1'h0;
			rise <= 1'h0;
		end else begin
			cnt <= next_cnt;
			bclk <= next_bclk;
			rise <= next_rise;
		end
	end
endmodule

// ===== empsh_mem_model.sv
// Far-side memory model: acknowledge on the cs4 pin and burst restart from a flash.
// Assumes its own free-running 80 ns clock, unrelated in phase to mclk.
`timescale 1ns/1ps
module empsh_mem_model (
	input wire logic out_en_n,
	input wire logic cs4_oe,
	input wire logic restart_cmd,
	output logic cs4_ack_pin,
	output logic burst_restart_n
);
	logic lclk = 1'h0;
	logic [1:0] w = 2'h0;
	initial burst_restart_n = 1'h1;
	initial #13 forever #40 lclk = ~lclk;
	always @(posedge lclk) begin
		// Ack only once the pin is an input and a read is under way
		if (!cs4_oe && !out_en_n) begin
			w <= (w == 2'h3) ? w : w + 2'h1;
		end else begin
			w <= 2'h0;
		end
		// Flash ends the burst on command
		burst_restart_n <= !restart_cmd;
	end
	// Released line sits at its pull-up level
	assign cs4_ack_pin = !(w == 2'h3);
endmodule

// ===== empsh_pkg.sv
// Package for the external memory pin sharing block: field positions, reset values, timing.
// Assumes a 100 MHz system clock and a 32-bit external data bus in four byte lanes.
package empsh_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int ADDR_W = 26;
	localparam int DATA_W = 32;
	localparam int LANES = 4;
	localparam int CS_W = 6;
	localparam int BANK_LSB = 16;
	localparam int BANK_W = 5;
	localparam int IBANK_LSB = 21;
	localparam int IBANK_W = 4;
	localparam int RC_LSB = 1;
	localparam int RC_PIN_W = 10;
	localparam int RC_W = 12;
	localparam int BOOT_W = 4;
	localparam int BOOT_MSB = 3;
	localparam logic FMUX_SDRAM_SEL_RST = 1'h1;
	localparam int BCLK_DIV = 4;
	localparam int BOOT_SETTLE_NS = 40;
	localparam int BOOT_SETTLE_CYC =
		(BOOT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	typedef enum logic [1:0] {
		EMPSH_OWN_IDLE,
		EMPSH_OWN_EXT,
		EMPSH_OWN_SDRAM,
		EMPSH_OWN_PCCARD
	} empsh_owner_type;
endpackage

// ===== empsh_sync.sv
// Two-flop synchroniser for a bus of pin inputs.
// Assumes inputs are asynchronous to mclk; the first stage feeds only the second.
`timescale 1ns/1ps
module empsh_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ===== empsh_top.sv
// Pin sharing for the external memory bus: strobes, selects, address muxing, boot straps.
// Assumes the internal controllers request ownership one at a time on mclk.
`timescale 1ns/1ps
// Functional notes
// R01 - Direction pin is high on reads and low on writes.
// R02 - Four active-low lane strobes: 0 for bits 31:24, 1 for 23:16, 2 for 15:8, 3 for 7:0.
// R03 - Strobe pins also carry SDRAM masks, strobe 2 carries card register and 3 card I/O read.
// R04 - Active-low output enable lets memories drive data on reads and also carries card I/O write.
// R05 - Chip selects 3:2 share pins with SDRAM selects 1:0, SDRAM selects routed after reset.
// R06 - Chip select 4 pin may instead be an input where the memory acknowledges its data phase.
// R07 - A burst flash pulls burst restart low to end a burst, and a new long burst begins.
// R08 - Address latch strobe goes low so burst memory captures the burst start address.
// R09 - A burst clock goes out to synchronous memories while in burst mode.
// R10 - Boot mode is caught from four strap pins at reset and the top strap must be low.
// R11 - Non-interleaved SDRAM bank address goes out on address pins 20:16.
// R12 - Interleaved SDRAM bank address goes out on address pins 24:21.
// R13 - SDRAM row/column address is 12 bits, low ten on address pins 10:1.
// R14 - SDRAM mask 3 covers bits 31:24 down to mask 0 for bits 7:0, per the mask map.
// R15 - Only the owning controller drives shared pins, others are held inactive.
module empsh_top (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic fmux_sdram_sel,
	input wire logic fmux_ack_sel,
	input wire logic ext_req,
	input wire logic ext_read,
	input wire logic [empsh_pkg::ADDR_W-1:0] ext_addr,
	input wire logic [empsh_pkg::LANES-1:0] ext_lane_en,
	input wire logic [empsh_pkg::CS_W-1:0] ext_cs,
	input wire logic ext_burst,
	input wire logic ext_burst_start,
	input wire logic sdr_req,
	input wire logic sdr_interleave,
	input wire logic [1:0] sdr_sel,
	input wire logic [empsh_pkg::BANK_W-1:0] sdr_bank_addr,
	input wire logic [empsh_pkg::IBANK_W-1:0] sdr_interleave_bank_addr,
	input wire logic [empsh_pkg::RC_W-1:0] sdr_row_col_addr,
	input wire logic [empsh_pkg::LANES-1:0] sdr_mask,
	input wire logic pc_req,
	input wire logic pc_reg,
	input wire logic pc_iord,
	input wire logic pc_iowr,
	input wire logic pc_we,
	input wire logic [empsh_pkg::BOOT_W-1:0] boot_pins,
	input wire logic cs4_ack_pin,
	input wire logic burst_restart_n,
	output logic [empsh_pkg::ADDR_W-1:0] addr_pin,
	output logic [empsh_pkg::LANES-1:0] byte_lane_strobe_n,
	output logic out_en_n,
	output logic rw_pin,
	output logic [empsh_pkg::CS_W-1:0] cs_out_n,
	output logic cs4_oe,
	output logic [1:0] sdram_select_n,
	output logic burst_addr_latch_n,
	output logic bclk,
	output logic ext_transfer_ack,
	output logic burst_restart,
	output logic [empsh_pkg::BOOT_W-1:0] boot_mode,
	output logic boot_valid,
	output logic boot_strap_err,
	output logic [1:0] owner
);
	localparam int LN = empsh_pkg::LANES;
	localparam int CW = empsh_pkg::CS_W;
	localparam int AW = empsh_pkg::ADDR_W;
	localparam int BW = empsh_pkg::BOOT_W;
	localparam int SETTLE = empsh_pkg::BOOT_SETTLE_CYC;

	// Strobe index i qualifies byte lane LN-1-i; mask index i qualifies lane i
	function automatic logic [LN-1:0] lane_to_strobe(input logic [LN-1:0] lanes);
		logic [LN-1:0] s;
		s = '0;
		for (int i = 0; i < LN; i++) begin
			s[i] = lanes[LN-1-i];
		end
		return s;
	endfunction

	logic [BW-1:0] boot_s;
	logic ack_s;
	logic restart_n_s;
	empsh_sync #(.W(BW), .RST_VAL('0)) u_boot_sync (
		.mclk(mclk),
		.nrst(nrst),
		.d(boot_pins),
		.q(boot_s)
	);
	empsh_sync #(.W(2), .RST_VAL(2'h3)) u_pin_sync (
		.mclk(mclk),
		.nrst(nrst),
		.d({cs4_ack_pin, burst_restart_n}),
		.q({ack_s, restart_n_s})
	);

	// Ownership: one controller at a time, external bus first, then SDRAM, then card
	empsh_pkg::empsh_owner_type own;
	empsh_pkg::empsh_owner_type next_own;
	always_comb begin
		next_own = own;
		case (own)
			empsh_pkg::EMPSH_OWN_IDLE: begin
				if (ext_req) next_own = empsh_pkg::EMPSH_OWN_EXT;
				else if (sdr_req) next_own = empsh_pkg::EMPSH_OWN_SDRAM;
				else if (pc_req) next_own = empsh_pkg::EMPSH_OWN_PCCARD;
			end
			empsh_pkg::EMPSH_OWN_EXT: if (!ext_req) next_own = empsh_pkg::EMPSH_OWN_IDLE;
			empsh_pkg::EMPSH_OWN_SDRAM: if (!sdr_req) next_own = empsh_pkg::EMPSH_OWN_IDLE;
			empsh_pkg::EMPSH_OWN_PCCARD: if (!pc_req) next_own = empsh_pkg::EMPSH_OWN_IDLE;
			default: next_own = empsh_pkg::EMPSH_OWN_IDLE;
		endcase
	end

	logic burst_run;
	logic bclk_int;
	logic bclk_rise;
	assign burst_run = (own == empsh_pkg::EMPSH_OWN_EXT) && ext_burst;
	empsh_bclk #(.DIV(empsh_pkg::BCLK_DIV)) u_bclk (
		.mclk(mclk),
		.nrst(nrst),
		.run(burst_run),
		.bclk(bclk_int),
		.rise(bclk_rise)
	);

	// Pin values other than bclk, computed here and registered below
	logic [AW-1:0] next_addr;
	logic [LN-1:0] next_strobe;
	logic next_oe_n;
	logic next_rw;
	logic [CW-1:0] next_cs;
	logic next_cs4_oe;
	logic [1:0] next_sdsel;
	logic next_latch_n;
	logic next_ack;
	logic next_restart;
	logic restart_d;
	always_comb begin
		next_addr = '0;
		next_strobe = '1;
		next_oe_n = 1'h1;
		next_rw = 1'h1;
		next_cs = '1;
		next_sdsel = 2'h3;
		next_latch_n = 1'h1;
		next_cs4_oe = !fmux_ack_sel; // see R06
		next_ack = fmux_ack_sel && !ack_s && (own == empsh_pkg::EMPSH_OWN_EXT); // see R06
		next_restart = !restart_n_s && restart_d && burst_run; // see R07
		case (own)
			empsh_pkg::EMPSH_OWN_EXT: begin
				next_addr = ext_addr;
				next_rw = ext_read; // see R01
				next_oe_n = !ext_read; // see R04
				next_strobe = ~lane_to_strobe(ext_lane_en); // see R02
				next_cs = ~ext_cs;
				// Restart latches the address again so the flash starts its long first access
				next_latch_n = !(ext_burst && (ext_burst_start || next_restart)); // see R08
			end
			empsh_pkg::EMPSH_OWN_SDRAM: begin
				next_addr[empsh_pkg::RC_LSB +: empsh_pkg::RC_PIN_W] =
					sdr_row_col_addr[empsh_pkg::RC_PIN_W-1:0]; // see R13
				if (sdr_interleave) begin
					next_addr[empsh_pkg::IBANK_LSB +: empsh_pkg::IBANK_W] =
						sdr_interleave_bank_addr; // see R12
				end else begin
					next_addr[empsh_pkg::BANK_LSB +: empsh_pkg::BANK_W] =
						sdr_bank_addr; // see R11
				end
				next_strobe = sdr_mask; // see R03 see R14
				next_sdsel = ~sdr_sel;
			end
			empsh_pkg::EMPSH_OWN_PCCARD: begin
				next_strobe[2] = !pc_reg; // see R03
				next_strobe[3] = !pc_iord; // see R03
				next_oe_n = !pc_iowr; // see R04
				next_rw = !pc_we;
			end
			default: begin
			end
		endcase
		// Shared select pins: the unselected function stays inactive
		if (fmux_sdram_sel) begin
			next_cs[3:2] = next_sdsel; // see R05 see R15
		end
		if (fmux_ack_sel) begin
			next_cs[4] = 1'h1; // see R06
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			own <= empsh_pkg::EMPSH_OWN_IDLE;
			addr_pin <= '0;
			byte_lane_strobe_n <= '1;
			out_en_n <= 1'h1;
			rw_pin <= 1'h1;
			cs_out_n <= '1;
			cs4_oe <= 1'h1;
			sdram_select_n <= 2'h3;
			burst_addr_latch_n <= 1'h1;
			bclk <= 1'h0;
			ext_transfer_ack <= 1'h0;
			burst_restart <= 1'h0;
			restart_d <= 1'h1;
		end else begin
			own <= next_own;
			addr_pin <= next_addr;
			byte_lane_strobe_n <= next_strobe;
			out_en_n <= next_oe_n;
			rw_pin <= next_rw;
			cs_out_n <= next_cs;
			cs4_oe <= next_cs4_oe;
			// Dedicated selects stay quiet while the shared pins carry chip selects
			sdram_select_n <= fmux_sdram_sel ? next_sdsel : 2'h3; // see R15
			burst_addr_latch_n <= next_latch_n;
			bclk <= bclk_int; // see R09
			ext_transfer_ack <= next_ack;
			burst_restart <= next_restart;
			restart_d <= restart_n_s;
		end
	end
	assign owner = own;

	// Boot straps: caught after release once the synchroniser has settled
	logic [3:0] settle_cnt;
	logic [3:0] next_settle_cnt;
	logic [BW-1:0] next_boot_mode;
	logic next_boot_valid;
	logic next_strap_err;
	always_comb begin
		next_settle_cnt = settle_cnt;
		next_boot_mode = boot_mode;
		next_boot_valid = boot_valid;
		next_strap_err = boot_strap_err;
		if (!boot_valid) begin
			if (settle_cnt == 4'(SETTLE)) begin
				next_boot_mode = boot_s; // see R10
				next_boot_valid = 1'h1;
				next_strap_err = boot_s[empsh_pkg::BOOT_MSB]; // see R10
			end else begin
				next_settle_cnt = settle_cnt + 4'h1;
			end
		end
	end
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			settle_cnt <= 4'h0;
			boot_mode <= '0;
			boot_valid <= 1'h0;
			boot_strap_err <= 1'h0;
		end else begin
			settle_cnt <= next_settle_cnt;
			boot_mode <= next_boot_mode;
			boot_valid <= next_boot_valid;
			boot_strap_err <= next_strap_err;
		end
	end

	a_rw_read_high: assert property (@(posedge mclk) disable iff (!nrst) // see R01
		(own == empsh_pkg::EMPSH_OWN_EXT && next_own == empsh_pkg::EMPSH_OWN_EXT)
		|=> (rw_pin == $past(ext_read)))
		else $error("direction pin does not follow read flag");
	a_strobe_lane_map: assert property (@(posedge mclk) disable iff (!nrst) // see R02
		(own == empsh_pkg::EMPSH_OWN_EXT) |=> (byte_lane_strobe_n[0] == !$past(ext_lane_en[3])))
		else $error("strobe 0 not tied to top lane");
	a_mask_lane_map: assert property (@(posedge mclk) disable iff (!nrst) // see R14
		(own == empsh_pkg::EMPSH_OWN_SDRAM) |=> (byte_lane_strobe_n == $past(sdr_mask)))
		else $error("mask lanes misrouted");
	a_oe_read: assert property (@(posedge mclk) disable iff (!nrst) // see R04
		(own == empsh_pkg::EMPSH_OWN_EXT && !ext_read) |=> out_en_n)
		else $error("output enable asserted on write");
	a_sdsel_default: assert property (@(posedge mclk) disable iff (!nrst) // see R05
		(own == empsh_pkg::EMPSH_OWN_SDRAM && fmux_sdram_sel)
		|=> (cs_out_n[3:2] == ~$past(sdr_sel)))
		else $error("SDRAM selects not on shared pins");
	a_no_contend: assert property (@(posedge mclk) disable iff (!nrst) // see R15
		(own != empsh_pkg::EMPSH_OWN_SDRAM) |=> (sdram_select_n == 2'h3))
		else $error("SDRAM select driven without ownership");
	a_bank_noil: assert property (@(posedge mclk) disable iff (!nrst) // see R11
		(own == empsh_pkg::EMPSH_OWN_SDRAM && !sdr_interleave)
		|=> (addr_pin[20:16] == $past(sdr_bank_addr)))
		else $error("bank address missing on pins 20:16");
	a_bank_il: assert property (@(posedge mclk) disable iff (!nrst) // see R12
		(own == empsh_pkg::EMPSH_OWN_SDRAM && sdr_interleave)
		|=> (addr_pin[24:21] == $past(sdr_interleave_bank_addr)))
		else $error("interleave bank missing on pins 24:21");
	a_rowcol_pins: assert property (@(posedge mclk) disable iff (!nrst) // see R13
		(own == empsh_pkg::EMPSH_OWN_SDRAM) |=> (addr_pin[10:1] == $past(sdr_row_col_addr[9:0])))
		else $error("row/column address misplaced");
	a_boot_catch: assert property (@(posedge mclk) disable iff (!nrst) // see R10
		$rose(boot_valid) |-> (boot_strap_err == boot_mode[3]))
		else $error("strap error not from top boot bit");
	a_bclk_idle: assert property (@(posedge mclk) disable iff (!nrst) // see R09
		!burst_run [*3] |-> !bclk)
		else $error("burst clock runs outside burst mode");
	a_bclk_rise: assert property (@(posedge mclk) disable iff (!nrst) // see R09
		bclk_rise |=> bclk)
		else $error("burst clock pin misses a rising edge");
	a_ack_owner: assert property (@(posedge mclk) disable iff (!nrst) // see R06
		ext_transfer_ack |-> ($past(own) == empsh_pkg::EMPSH_OWN_EXT))
		else $error("acknowledge passed without external bus ownership");
	a_cs4_released: assert property (@(posedge mclk) disable iff (!nrst) // see R06
		fmux_ack_sel |=> (!cs4_oe && cs_out_n[4]))
		else $error("cs4 pin still driven while used as acknowledge");
	a_latch_restart: assert property (@(posedge mclk) disable iff (!nrst) // see R08
		burst_restart |-> !burst_addr_latch_n)
		else $error("restart did not latch the address again");
endmodule

// ===== tb.sv
// Bench for the pin sharing block: owner cycles, boot straps, burst and ack.
// Assumes the memory model drives the ack and restart pins on its own clock.
`timescale 1ns/1ps
module tb;
	logic mclk = 1'h0;
	logic nrst = 1'h0;
	logic fss = empsh_pkg::FMUX_SDRAM_SEL_RST, fas = 1'h0, er = 1'h0, erd = 1'h0;
	logic bst = 1'h0, bsts = 1'h0;
	logic sr = 1'h0, sil = 1'h0, pr = 1'h0, preg = 1'h0, piord = 1'h0, piowr = 1'h0;
	logic pwe = 1'h0, rcmd = 1'h0;
	logic [25:0] ea = '0, adr;
	logic [3:0] eln = '0, smk = '0, iba = '0, bp = '0, strb, bm;
	logic [5:0] ecs = '0, cso;
	logic [1:0] ssl = '0, sds, own;
	logic [4:0] ba = '0;
	logic [11:0] rc = '0;
	logic oe, rw, c4oe, lat, bck, ack, rst, bv, berr, ackm, rstn;
	logic [79:0] q[$];
	logic [79:0] qe;
	logic [31:0] rs = 32'h51C4E5FD;
	event smp;
	int failures = 0, n_checks = 0, cyc = 0, k, n;
	wire [39:0] pins = {rw, oe, strb, cso, sds, adr};
	wire ackw = c4oe ? cso[4] : ackm;
	always #5 mclk = ~mclk;
	empsh_top u_dut (.mclk(mclk), .nrst(nrst), .fmux_sdram_sel(fss), .fmux_ack_sel(fas),
		.ext_req(er), .ext_read(erd), .ext_addr(ea), .ext_lane_en(eln), .ext_cs(ecs),
		.ext_burst(bst), .ext_burst_start(bsts), .sdr_req(sr), .sdr_interleave(sil),
		.sdr_sel(ssl), .sdr_bank_addr(ba), .sdr_interleave_bank_addr(iba),
		.sdr_row_col_addr(rc), .sdr_mask(smk), .pc_req(pr), .pc_reg(preg),
		.pc_iord(piord), .pc_iowr(piowr), .pc_we(pwe), .boot_pins(bp),
		.cs4_ack_pin(ackw), .burst_restart_n(rstn), .addr_pin(adr),
		.byte_lane_strobe_n(strb), .out_en_n(oe), .rw_pin(rw), .cs_out_n(cso),
		.cs4_oe(c4oe), .sdram_select_n(sds), .burst_addr_latch_n(lat), .bclk(bck),
		.ext_transfer_ack(ack), .burst_restart(rst), .boot_mode(bm), .boot_valid(bv),
		.boot_strap_err(berr), .owner(own));
	empsh_mem_model u_mem (.out_en_n(oe), .cs4_oe(c4oe), .restart_cmd(rcmd),
		.cs4_ack_pin(ackm), .burst_restart_n(rstn));
	function automatic logic [31:0] xs(logic [31:0] v);
		v ^= v << 13;
		v ^= v >> 17;
		v ^= v << 5;
		return v;
	endfunction
	task conclude();
		if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task cmp(string s, logic [39:0] e, logic [39:0] g);
		n_checks++;
		if (g !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", s, e, g);
		end
	endtask
	task clk(int c);
		repeat (c) @(posedge mclk);
		#1;
	endtask
	task note(logic [39:0] e, logic [39:0] m);
		q.push_back({e, m});
		-> smp;
	endtask
	always @(smp) begin
		while (q.size() > 0) begin
			qe = q.pop_front();
			cmp("pins", qe[79:40] & qe[39:0], pins & qe[39:0]);
		end
	end
	always @(posedge mclk) begin
		cyc++;
		// Whole run needs under 400 cycles
		if (cyc == 6000) begin
			failures++;
			conclude();
		end
	end
	task eop(logic rd);
		rs = xs(rs);
		er = 1'h1;
		erd = rd;
		ea = rs[25:0];
		eln = rs[29:26];
		sr = rs[30];
		rs = xs(rs);
		ecs = rs[5:0];
		clk(2);
		cmp("owner", 40'(empsh_pkg::EMPSH_OWN_EXT), {38'h0, own});
		note({rd, !rd, ~{eln[0], eln[1], eln[2], eln[3]}, ~ecs | (fss ? 6'h0C : 6'h00),
			2'h3, ea}, '1);
		er = 1'h0;
		sr = 1'h0;
		clk(2);
		cmp("idle", 40'(empsh_pkg::EMPSH_OWN_IDLE), {38'h0, own});
		note({2'h3, 4'hF, 6'h3F, 2'h3, 26'h0}, 40'hFFFC000000);
	endtask
	task sop(logic il);
		logic [25:0] a, am;
		rs = xs(rs);
		sr = 1'h1;
		sil = il;
		{smk, rc, iba, ba, ssl} = rs[26:0];
		clk(2);
		a = (il ? {1'h0, iba, 21'h0} : {5'h0, ba, 16'h0}) | {15'h0, rc[9:0], 1'h0};
		am = (il ? 26'h1E00000 : 26'h01F0000) | 26'h00007FE;
		cmp("owner", 40'(empsh_pkg::EMPSH_OWN_SDRAM), {38'h0, own});
		note({2'h0, smk, fss ? {2'h3, ~ssl, 2'h3} : 6'h3F, fss ? ~ssl : 2'h3, a},
			{2'h0, 4'hF, 6'h3F, 2'h3, am});
		sr = 1'h0;
		clk(2);
	endtask
	task pc(logic [2:0] v);
		rs = xs(rs);
		pr = 1'h1;
		pwe = rs[0];
		{preg, piord, piowr} = v;
		clk(2);
		cmp("owner", 40'(empsh_pkg::EMPSH_OWN_PCCARD), {38'h0, own});
		note({!pwe, ~v[0], ~v[1], ~v[2], 2'h3, 6'h3F, 2'h3, 26'h0}, '1);
		pr = 1'h0;
		clk(2);
	endtask
	task boot(logic [3:0] v);
		bp = v;
		nrst = 1'h0;
		clk(16);
		note({2'h3, 4'hF, 6'h3F, 2'h3, 26'h0}, '1);
		nrst = 1'h1;
		clk(4);
		cmp("bvalid", 40'h0, {39'h0, bv});
		clk(1);
		cmp("boot", {34'h0, 1'h1, v[3], v}, {34'h0, bv, berr, bm});
		bp = ~v;
		clk(4);
		cmp("bheld", {36'h0, v}, {36'h0, bm});
	endtask
	initial begin
		boot(4'h5);
		for (k = 0; k < 8; k++) pc(k[2:0]);
		for (k = 0; k < 20; k++) eop(rs[9]);
		fss = 1'h0;
		eop(1'h1);
		sop(1'h0);
		fss = 1'h1;
		for (k = 0; k < 6; k++) sop(k[0]);
		er = 1'h1;
		bst = 1'h1;
		clk(2);
		bsts = 1'h1;
		clk(1);
		bsts = 1'h0;
		for (k = 0; k < 8 && lat !== 1'h0; k++) clk(1);
		cmp("latch", 40'h0, {39'h0, lat});
		n = 0;
		for (k = 0; k < 16; k++) begin
			clk(1);
			n += (bck === 1'h1);
		end
		// Divide by four gives half of 16 cycles high
		cmp("bclk", 40'h8, 40'(n));
		rcmd = 1'h1;
		for (k = 0; k < 40 && rst !== 1'h1; k++) clk(1);
		cmp("restart", 40'h1, {39'h0, rst});
		cmp("relatch", 40'h0, {39'h0, lat});
		clk(1);
		cmp("rpulse", 40'h0, {39'h0, rst});
		rcmd = 1'h0;
		er = 1'h0;
		bst = 1'h0;
		clk(12);
		cmp("bidle", 40'h0, {39'h0, bck});
		fas = 1'h1;
		clk(2);
		cmp("c4oe", 40'h0, {39'h0, c4oe});
		er = 1'h1;
		erd = 1'h1;
		ecs = 6'h10;
		for (k = 0; k < 60 && ack !== 1'h1; k++) clk(1);
		cmp("ack", 40'h1, {39'h0, ack});
		er = 1'h0;
		for (k = 0; k < 60 && ack !== 1'h0; k++) clk(1);
		cmp("noack", 40'h0, {39'h0, ack});
		fas = 1'h0;
		boot(4'hA);
		conclude();
	end
endmodule
